/* core/tmr_ctl_pkg.sv */
// Constants for the timer control and external interrupt flag block
// Summary of operation
// - Timer 0/1 overflow sets flag, vector clears
// - Software run bits start/stop timers 0/1
// - Irq1 flag set on either edge, ack clears
// - Irq1 type bit picks edge or low level
// - Irq0 flag set on falling edge, ack clears
// - Irq0 type bit picks falling edge or level
// - Timer 2 overflow flag: software clear only
// - Pin fall with enable sets external flag
// - Auto-reload with run bit set: wrap toggles external flag
// - Rx clock select: timer 2 else timer 1
// - Tx clock select: timer 2 else timer 1
// - Enabled pin fall captures or reloads, interrupts
// - Up/down auto-reload ignores external enable
// - Other modes: pin fall only flags, interrupts
// - External enable low ignores the pin
// - Timer 2 run bit starts and stops it
// - Source select: counter when 1, timer else
// - Capture/reload select picks capture or reload
package tmr_ctl_pkg;
  localparam logic [11:0] CTL_ADDR    = 12'h000;
  localparam logic [11:0] T2CTL_ADDR  = 12'h004;
  localparam logic [11:0] STAT_ADDR   = 12'h008;
  localparam logic [11:0] CLR_ADDR    = 12'h00C;
  localparam logic [11:0] EN_ADDR     = 12'h010;
  localparam logic [11:0] T2MODE_ADDR = 12'h014;
  // Timer run and interrupt control bit positions
  localparam int T1_OVF_BIT  = 7;
  localparam int T1_RUN_BIT  = 6;
  localparam int T0_OVF_BIT  = 5;
  localparam int T0_RUN_BIT  = 4;
  localparam int X1_FLAG_BIT = 3;
  localparam int X1_TYPE_BIT = 2;
  localparam int X0_FLAG_BIT = 1;
  localparam int X0_TYPE_BIT = 0;
  // Timer 2 control bit positions
  localparam int T2_OVF_BIT  = 7;
  localparam int T2_EXT_BIT  = 6;
  localparam int RXS_BIT     = 5;
  localparam int TXS_BIT     = 4;
  localparam int PIN_EN_BIT  = 3;
  localparam int T2_RUN_BIT  = 2;
  localparam int SRC_BIT     = 1;
  localparam int CPRL_BIT    = 0;
  // Mode register bit positions
  localparam int DIR_EN_BIT = 0;
  localparam int BAUD_BIT  = 1;
  localparam int CLKO_BIT  = 2;
  // Interrupt status layout
  localparam int NUM_EV    = 6;
  localparam int EV_T0_OVF = 0;
  localparam int EV_T1_OVF = 1;
  localparam int EV_X0     = 2;
  localparam int EV_X1     = 3;
  localparam int EV_T2_OVF = 4;
  localparam int EV_T2_EXT = 5;
  localparam logic [7:0] CTL_RST   = 8'h00;
  localparam logic [7:0] T2CTL_RST = 8'h00;
  localparam logic [2:0] T2MODE_RST = 3'h0;
  localparam logic [NUM_EV-1:0] EN_RST = 6'h00;
  localparam int SYNC_STAGES = 2;
endpackage

/* core/pin_sync_edge.sv */
// Two-flop synchroniser with rise and fall pulses
`timescale 1ns/1ns
module pin_sync_edge
  import tmr_ctl_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [SYNC_STAGES-1:0] sync;
  logic                   last;
  logic [SYNC_STAGES-1:0] next_sync;
  logic                   next_last;

  always_comb begin
    next_sync = {sync[SYNC_STAGES-2:0], pin};
    next_last = sync[SYNC_STAGES-1];
  end

  // Only the last stage feeds the edge logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync <= '1;
      last <= 1'b1;
    end else begin
      sync <= next_sync;
      last <= next_last;
    end
  end

  assign level = sync[SYNC_STAGES-1];
  assign rise  = level & ~last;
  assign fall  = ~level & last;

  one_fall_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fall |=> !fall)
    else $error("fall pulse lasted two cycles");
endmodule

/* core/tmr_ctl.sv */
// Timer run control, overflow and external interrupt flags, AHB-Lite slave
`timescale 1ns/1ns
module tmr_ctl
  import tmr_ctl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        timer0_wrap,
  input  wire logic        timer1_wrap,
  input  wire logic        timer2_wrap,
  input  wire logic        ext_irq0_n,
  input  wire logic        ext_irq1_n,
  input  wire logic        timer2_external_pin,
  input  wire logic        vector_t0_ovf,
  input  wire logic        vector_t1_ovf,
  input  wire logic        vector_ext0,
  input  wire logic        vector_ext1,
  output logic             timer0_run,
  output logic             timer1_run,
  output logic             timer2_run,
  output logic             timer2_source_select,
  output logic             capture_reload_select,
  output logic             count_direction_enable,
  output logic             timer2_capture,
  output logic             timer2_reload,
  output logic             uart_rx_tick,
  output logic             uart_tx_tick,
  output logic             ext_irq0_req,
  output logic             ext_irq1_req,
  output logic             irq
);
  typedef enum {PH_IDLE, PH_WRITE, PH_READ} phase_t;

  phase_t      phase;
  phase_t      next_phase;
  logic [11:0] addr;
  logic [11:0] next_addr;
  logic [7:0]  timer_run_and_irq_control;
  logic [7:0]  next_ctl;
  logic [7:0]  timer2_control;
  logic [7:0]  next_t2ctl;
  logic        other_mode;
  logic [2:0]  t2mode;
  logic [2:0]  next_t2mode;
  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] next_status;
  logic [NUM_EV-1:0] enable;
  logic [NUM_EV-1:0] next_enable;
  logic [31:0] next_hrdata;
  logic        next_capture;
  logic        next_reload;
  logic        next_rx_tick;
  logic        next_tx_tick;
  logic        next_irq0_req;
  logic        next_irq1_req;
  logic        next_irq;
  logic        e0_lvl;
  logic        e0_fall;
  logic        e1_lvl;
  logic        e1_rise;
  logic        e1_fall;
  logic        t2_fall;
  logic        t2_lvl;
  logic        wr_go;
  logic        ext_event;
  logic        autoreload;
  logic        capture_mode;
  logic [NUM_EV-1:0] ev;

  pin_sync_edge sync_e0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (ext_irq0_n),
    .level   (e0_lvl),
    .rise    (),
    .fall    (e0_fall)
  );

  pin_sync_edge sync_e1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (ext_irq1_n),
    .level   (e1_lvl),
    .rise    (e1_rise),
    .fall    (e1_fall)
  );

  pin_sync_edge sync_t2 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     (timer2_external_pin),
    .level   (t2_lvl),
    .rise    (),
    .fall    (t2_fall)
  );

  function automatic logic [31:0] read_mux(
    input logic [11:0]       a,
    input logic [7:0]        tc,
    input logic [7:0]        t2c,
    input logic [2:0]        md,
    input logic [NUM_EV-1:0] st,
    input logic [NUM_EV-1:0] en
  );
    case (a)
      CTL_ADDR:    read_mux = {24'h000000, tc};
      T2CTL_ADDR:  read_mux = {24'h000000, t2c};
      STAT_ADDR:   read_mux = {26'h0000000, st};
      EN_ADDR:     read_mux = {26'h0000000, en};
      T2MODE_ADDR: read_mux = {29'h00000000, md};
      default:     read_mux = 32'h00000000;
    endcase
  endfunction

  // Bus phase tracking; the slave is always ready
  always_comb begin
    next_phase = PH_IDLE;
    next_addr  = addr;
    if (hsel && hready && htrans[1]) begin
      next_phase = hwrite ? PH_WRITE : PH_READ;
      next_addr  = haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= PH_IDLE;
      addr  <= 12'h000;
    end else begin
      phase <= next_phase;
      addr  <= next_addr;
    end
  end

  assign wr_go        = (phase == PH_WRITE);
  // Baud and clock-out modes are neither capture nor auto-reload
  assign other_mode   = t2mode[BAUD_BIT] | t2mode[CLKO_BIT];
  assign autoreload   = ~timer2_control[CPRL_BIT] & ~other_mode;
  assign capture_mode = timer2_control[CPRL_BIT] & ~other_mode;
  // External pin is acted on only when enabled and not up/down reload
  assign ext_event = t2_fall & timer2_control[PIN_EN_BIT]
    & ~(autoreload & t2mode[DIR_EN_BIT]);

  always_comb begin
    next_ctl    = timer_run_and_irq_control;
    next_t2ctl  = timer2_control;
    next_t2mode = t2mode;
    next_enable = enable;
    next_status = status;
    if (wr_go) begin
      case (addr)
        CTL_ADDR: begin
          // Software owns run and type bits
          next_ctl[T1_RUN_BIT]  = hwdata[T1_RUN_BIT];
          next_ctl[T0_RUN_BIT]  = hwdata[T0_RUN_BIT];
          next_ctl[X1_TYPE_BIT] = hwdata[X1_TYPE_BIT];
          next_ctl[X0_TYPE_BIT] = hwdata[X0_TYPE_BIT];
        end
        T2CTL_ADDR: begin
          // Flags here may only be cleared by a write of 0
          next_t2ctl[T2_OVF_BIT] = timer2_control[T2_OVF_BIT]
                                   & hwdata[T2_OVF_BIT];
          next_t2ctl[T2_EXT_BIT] = timer2_control[T2_EXT_BIT]
                                   & hwdata[T2_EXT_BIT];
          next_t2ctl[5:0] = hwdata[5:0];
        end
        T2MODE_ADDR: next_t2mode = hwdata[2:0];
        EN_ADDR:     next_enable = hwdata[NUM_EV-1:0];
        CLR_ADDR:    next_status = status & ~hwdata[NUM_EV-1:0];
        default: begin
        end
      endcase
    end
    // Vectoring clears; set below wins in the same cycle
    if (vector_t1_ovf) next_ctl[T1_OVF_BIT] = 1'b0;
    if (vector_t0_ovf) next_ctl[T0_OVF_BIT] = 1'b0;
    if (vector_ext1) next_ctl[X1_FLAG_BIT] = 1'b0;
    if (vector_ext0) next_ctl[X0_FLAG_BIT] = 1'b0;
    if (timer1_wrap) next_ctl[T1_OVF_BIT] = 1'b1;
    if (timer0_wrap) next_ctl[T0_OVF_BIT] = 1'b1;
    // Edge mode: irq1 both edges, irq0 falling only
    if (timer_run_and_irq_control[X1_TYPE_BIT] && (e1_rise || e1_fall))
      next_ctl[X1_FLAG_BIT] = 1'b1;
    if (timer_run_and_irq_control[X0_TYPE_BIT] && e0_fall)
      next_ctl[X0_FLAG_BIT] = 1'b1;
    if (timer2_wrap && !other_mode)
      next_t2ctl[T2_OVF_BIT] = 1'b1;
    if (timer2_wrap && autoreload && timer2_control[T2_RUN_BIT])
      next_t2ctl[T2_EXT_BIT] = ~next_t2ctl[T2_EXT_BIT];
    else if (ext_event)
      next_t2ctl[T2_EXT_BIT] = 1'b1;
    ev[EV_T0_OVF] = timer0_wrap;
    ev[EV_T1_OVF] = timer1_wrap;
    ev[EV_X0] = next_ctl[X0_FLAG_BIT]
                & ~timer_run_and_irq_control[X0_FLAG_BIT];
    ev[EV_X1] = next_ctl[X1_FLAG_BIT]
                & ~timer_run_and_irq_control[X1_FLAG_BIT];
    ev[EV_T2_OVF] = next_t2ctl[T2_OVF_BIT] & ~timer2_control[T2_OVF_BIT];
    ev[EV_T2_EXT] = next_t2ctl[T2_EXT_BIT] & ~timer2_control[T2_EXT_BIT];
    next_status = next_status | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_run_and_irq_control <= CTL_RST;
      timer2_control            <= T2CTL_RST;
      t2mode                    <= T2MODE_RST;
      status                    <= '0;
      enable                    <= EN_RST;
    end else begin
      timer_run_and_irq_control <= next_ctl;
      timer2_control            <= next_t2ctl;
      t2mode                    <= next_t2mode;
      status                    <= next_status;
      enable                    <= next_enable;
    end
  end

  // Registered outputs
  always_comb begin
    next_hrdata = read_mux(next_addr, next_ctl, next_t2ctl, next_t2mode,
                           next_status, next_enable);
    next_capture = ext_event & capture_mode;
    next_reload  = ext_event & autoreload;
    next_rx_tick = timer2_control[RXS_BIT] ? timer2_wrap
                                           : timer1_wrap;
    next_tx_tick = timer2_control[TXS_BIT] ? timer2_wrap
                                           : timer1_wrap;
    // Level mode requests follow the low pin
    next_irq0_req = timer_run_and_irq_control[X0_TYPE_BIT]
                    ? next_ctl[X0_FLAG_BIT] : ~e0_lvl;
    next_irq1_req = timer_run_and_irq_control[X1_TYPE_BIT]
                    ? next_ctl[X1_FLAG_BIT] : ~e1_lvl;
    next_irq = |(next_status & next_enable);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata                 <= 32'h00000000;
      timer2_capture         <= 1'b0;
      timer2_reload          <= 1'b0;
      uart_rx_tick           <= 1'b0;
      uart_tx_tick           <= 1'b0;
      ext_irq0_req           <= 1'b0;
      ext_irq1_req           <= 1'b0;
      irq                    <= 1'b0;
      timer0_run             <= 1'b0;
      timer1_run             <= 1'b0;
      timer2_run             <= 1'b0;
      timer2_source_select   <= 1'b0;
      capture_reload_select  <= 1'b0;
      count_direction_enable <= 1'b0;
    end else begin
      hrdata                 <= next_hrdata;
      timer2_capture         <= next_capture;
      timer2_reload          <= next_reload;
      uart_rx_tick           <= next_rx_tick;
      uart_tx_tick           <= next_tx_tick;
      ext_irq0_req           <= next_irq0_req;
      ext_irq1_req           <= next_irq1_req;
      irq                    <= next_irq;
      timer0_run             <= next_ctl[T0_RUN_BIT];
      timer1_run             <= next_ctl[T1_RUN_BIT];
      timer2_run             <= next_t2ctl[T2_RUN_BIT];
      timer2_source_select   <= next_t2ctl[SRC_BIT];
      capture_reload_select  <= next_t2ctl[CPRL_BIT];
      count_direction_enable <= next_t2mode[DIR_EN_BIT];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  t0_ovf_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timer0_wrap |=> timer_run_and_irq_control[T0_OVF_BIT])
    else $error("timer 0 overflow flag not set");
  t1_vec_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    vector_t1_ovf && !timer1_wrap
    |=> !timer_run_and_irq_control[T1_OVF_BIT])
    else $error("timer 1 flag not cleared on vector");
  x1_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timer_run_and_irq_control[X1_TYPE_BIT] && e1_rise
    |=> timer_run_and_irq_control[X1_FLAG_BIT])
    else $error("irq1 rising edge missed");
  x0_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
    e0_lvl && !$past(e0_lvl) && !timer_run_and_irq_control[X0_FLAG_BIT]
    && !e0_fall |=> !timer_run_and_irq_control[X0_FLAG_BIT])
    else $error("irq0 flag set on rising edge");
  x0_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !timer_run_and_irq_control[X0_TYPE_BIT] && !e0_lvl
    && $stable(timer_run_and_irq_control[X0_TYPE_BIT]) |=> ext_irq0_req)
    else $error("irq0 level request missing");
  t2_ovf_baud_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !timer2_control[T2_OVF_BIT] && t2mode[BAUD_BIT]
    |=> !timer2_control[T2_OVF_BIT])
    else $error("timer 2 flag set in baud mode");
  pin_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !timer2_control[PIN_EN_BIT] |-> !timer2_capture[*1] ##1 !timer2_capture)
    else $error("capture with external enable low");
  rxsel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    timer2_control[RXS_BIT] && timer2_wrap |=> uart_rx_tick)
    else $error("rx tick not from timer 2");
  txsel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !timer2_control[TXS_BIT] && timer1_wrap |=> uart_tx_tick)
    else $error("tx tick not from timer 1");

  ext_cap_c: cover property (@(posedge hclk) timer2_capture);
  ext_rel_c: cover property (@(posedge hclk) timer2_reload);
  irq_c:     cover property (@(posedge hclk) irq);
endmodule

/* tb/core_model.sv */
// Processor-side model: timer overflow pulses, vectoring, UART tick counts
`timescale 1ns/1ns
module core_model (
  input  wire logic       hclk,
  input  wire logic       uart_rx_tick,
  input  wire logic       uart_tx_tick,
  output logic      [2:0] wrap,
  output logic      [3:0] vector
);
  logic [31:0] rx_ticks = 32'h0;
  logic [31:0] tx_ticks = 32'h0;
  initial begin
    wrap = 3'h0;
    vector = 4'h0;
  end
  always @(posedge hclk) begin
    rx_ticks <= rx_ticks + 32'(uart_rx_tick === 1'b1);
    tx_ticks <= tx_ticks + 32'(uart_tx_tick === 1'b1);
  end
  // One-cycle overflow pulse of timer n
  task automatic pulse_wrap(input int n);
    wrap[n] <= 1'b1;
    @(posedge hclk);
    wrap[n] <= 1'b0;
  endtask
  // Vectoring after a prompt or slow delay clears the flag behind it
  task automatic take_vector(input int n, input int dly);
    repeat (dly) @(posedge hclk);
    vector[n] <= 1'b1;
    @(posedge hclk);
    vector[n] <= 1'b0;
  endtask
endmodule

/* tb/tmr_ctl_tb.sv */
// Self-checking bench for the timer control and interrupt flag block
`timescale 1ns/1ns
module tmr_ctl_tb;
  localparam logic [11:0] ctl_a = 12'h000;
  localparam logic [11:0] t2_a  = 12'h004;
  localparam logic [11:0] st_a  = 12'h008;
  localparam logic [11:0] clr_a = 12'h00C;
  localparam logic [11:0] en_a  = 12'h010;
  localparam logic [11:0] md_a  = 12'h014;
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  ext_n;
  logic        t2_pin;
  logic [2:0]  wrap;
  logic [3:0]  vector;
  logic [5:0]  runs;
  logic [1:0]  req;
  logic        cap;
  logic        rel;
  logic        rx_tick;
  logic        tx_tick;
  logic        irq;
  int          errors = 0;
  int          checks = 0;
  int          cap_cnt = 0;
  int          rel_cnt = 0;
  always #5 hclk = ~hclk;
  tmr_ctl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .timer0_wrap(wrap[0]), .timer1_wrap(wrap[1]),
    .timer2_wrap(wrap[2]), .ext_irq0_n(ext_n[0]), .ext_irq1_n(ext_n[1]),
    .timer2_external_pin(t2_pin), .vector_t0_ovf(vector[0]),
    .vector_t1_ovf(vector[1]), .vector_ext0(vector[2]),
    .vector_ext1(vector[3]),
    .timer0_run(runs[0]), .timer1_run(runs[1]), .timer2_run(runs[2]),
    .timer2_source_select(runs[3]), .capture_reload_select(runs[4]),
    .count_direction_enable(runs[5]), .timer2_capture(cap),
    .timer2_reload(rel), .uart_rx_tick(rx_tick), .uart_tx_tick(tx_tick),
    .ext_irq0_req(req[0]), .ext_irq1_req(req[1]), .irq(irq));
  core_model core (.hclk(hclk), .uart_rx_tick(rx_tick),
    .uart_tx_tick(tx_tick), .wrap(wrap), .vector(vector));
  always @(posedge hclk) begin
    cap_cnt <= cap_cnt + int'(cap === 1'b1);
    rel_cnt <= rel_cnt + int'(rel === 1'b1);
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // Single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask
  task automatic t_reset();
    logic [11:0] a [7] = '{ctl_a, t2_a, st_a, clr_a, en_a, md_a, 12'h018};
    wr(12'h018, 32'hFF);
    for (int i = 0; i < 7; i++) rdchk("reset value", a[i], 32'h0);
    chk("idle outputs", 32'h0, 32'({irq, req, cap, rel, runs}));
  endtask
  task automatic t_run();
    wr(ctl_a, 32'h50);
    wr(t2_a, 32'h07);
    wr(md_a, 32'h01);
    tick(2);
    chk("run outputs", 32'h3F, 32'(runs));
    rdchk("run ctl", ctl_a, 32'h50);
    wr(ctl_a, 32'h10);
    wr(t2_a, 32'h00);
    wr(md_a, 32'h00);
    tick(2);
    chk("run stop", 32'h01, 32'(runs));
    wr(ctl_a, 32'h00);
  endtask
  task automatic t_ovf(input int n);
    logic [31:0] f;
    f = n ? 32'h80 : 32'h20;
    wr(en_a, 32'(1 << n));
    core.pulse_wrap(n);
    tick(3);
    rdchk("ovf flag", ctl_a, f);
    chk("irq on", 32'h1, 32'(irq));
    core.take_vector(n, 4 * n);
    tick(2);
    rdchk("ovf vector", ctl_a, 32'h0);
    rdchk("status", st_a, 32'(1 << n));
    wr(clr_a, 32'(1 << n));
    tick(2);
    chk("irq off", 32'h0, 32'(irq));
    wr(en_a, 32'h0);
    core.pulse_wrap(n);
    tick(3);
    chk("irq masked", 32'h0, 32'(irq));
    rdchk("masked status", st_a, 32'(1 << n));
    core.take_vector(n, 0);
    wr(clr_a, 32'h3F);
    rdchk("status clear", st_a, 32'h0);
  endtask
  task automatic t_uart();
    logic [31:0] r0;
    logic [31:0] t0;
    logic [31:0] xr;
    logic [31:0] xt;
    for (int k = 0; k < 8; k++) begin
      wr(t2_a, 32'((k >> 1) << 4));
      r0 = core.rx_ticks;
      t0 = core.tx_ticks;
      xr = 32'(k[2] == k[0]);
      xt = 32'(k[1] == k[0]);
      core.pulse_wrap(1 + k % 2);
      tick(3);
      chk("rx ticks", r0 + xr, core.rx_ticks);
      chk("tx ticks", t0 + xt, core.tx_ticks);
    end
    core.take_vector(1, 0);
    wr(t2_a, 32'h0);
    wr(clr_a, 32'h3F);
  endtask
  task automatic t_ext(input int n);
    logic [31:0] it;
    logic [31:0] ie;
    it = n ? 32'h04 : 32'h01;
    ie = n ? 32'h08 : 32'h02;
    wr(ctl_a, it);
    ext_n[n] <= 1'b0;
    tick(6);
    rdchk("edge flag", ctl_a, it | ie);
    chk("edge req", 32'h1, 32'(req[n]));
    core.take_vector(2 + n, 4 * n);
    tick(2);
    rdchk("flag acked", ctl_a, it);
    ext_n[n] <= 1'b1;
    tick(6);
    rdchk("rise flag", ctl_a, n ? it | ie : it);
    core.take_vector(2 + n, 0);
    wr(ctl_a, 32'h0);
    ext_n[n] <= 1'b0;
    tick(6);
    chk("level req", 32'h1, 32'(req[n]));
    ext_n[n] <= 1'b1;
    tick(6);
    chk("level off", 32'h0, 32'(req[n]));
    wr(clr_a, 32'h3F);
  endtask
  task automatic t_timer2_external_pin();
    logic [31:0] t2c [5] = '{32'h01, 32'h09, 32'h08, 32'h08, 32'h08};
    logic [31:0] md [5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h2};
    logic [31:0] fl [5] = '{32'h0, 32'h40, 32'h40, 32'h0, 32'h40};
    int          ce [5] = '{0, 1, 0, 0, 0};
    int          re [5] = '{0, 0, 1, 0, 0};
    int          c0;
    int          r0;
    for (int i = 0; i < 5; i++) begin
      wr(md_a, md[i]);
      wr(t2_a, t2c[i]);
      c0 = cap_cnt;
      r0 = rel_cnt;
      t2_pin <= 1'b0;
      tick(6);
      t2_pin <= 1'b1;
      tick(6);
      rdchk("ext flag", t2_a, t2c[i] | fl[i]);
      chk("capture", 32'(c0 + ce[i]), 32'(cap_cnt));
      chk("reload", 32'(r0 + re[i]), 32'(rel_cnt));
      wr(t2_a, t2c[i]);
      rdchk("ext clear", t2_a, t2c[i]);
    end
    wr(md_a, 32'h0);
    wr(clr_a, 32'h3F);
  endtask
  task automatic t_tf2();
    logic [31:0] md [3] = '{32'h0, 32'h2, 32'h4};
    for (int i = 0; i < 3; i++) begin
      wr(md_a, md[i]);
      wr(t2_a, 32'h05);
      core.pulse_wrap(2);
      tick(3);
      rdchk("t2 ovf set", t2_a, i ? 32'h05 : 32'h85);
      wr(t2_a, 32'h05);
      rdchk("t2 ovf clear", t2_a, 32'h05);
    end
    wr(md_a, 32'h0);
    wr(t2_a, 32'h04);
    core.pulse_wrap(2);
    tick(3);
    rdchk("toggle on", t2_a, 32'hC4);
    core.pulse_wrap(2);
    tick(3);
    rdchk("toggle off", t2_a, 32'h84);
    wr(t2_a, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    $display("[ERR] watchdog expected finish seen hang");
    print_verdict();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_n = 2'h3;
    t2_pin = 1'b1;
    repeat (20) @(posedge hclk);
    chk("reset irq", 32'h0, 32'(irq));
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_run();
    t_ovf(0);
    t_ovf(1);
    t_uart();
    t_ext(0);
    t_ext(1);
    t_timer2_external_pin();
    t_tf2();
    print_verdict();
  end
endmodule
